// ==== bench/ocfr_chan_model.sv ====
// far-side model: retry timer of the supervised channels
// assumes the block's faulted_off_q levels and one sys_clk domain
`timescale 1ns/1ps
module ocfr_chan_model
    import ocfr_pkg::*;
#(
    parameter int CH = NUM_CH,
    parameter int RETRY_WAIT = 6
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // channel state from the block
    input wire logic [CH-1:0] faulted_off,
    // retry timer pulses, one per off period
    output logic [CH-1:0] retry_tick
);
    int off_cnt [CH]; // cycles spent faulted off, per channel

    // one tick per off period; the count keeps running so no second tick
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < CH; i++) begin
            if (rst || !faulted_off[i]) begin
                off_cnt[i] <= 0;
                retry_tick[i] <= 1'b0;
            end else begin
                off_cnt[i] <= off_cnt[i] + 1;
                retry_tick[i] <= (off_cnt[i] == RETRY_WAIT - 1);
            end
        end
    end
endmodule

// ==== bench/ocfr_core_tb_top.sv ====
// testbench for the current fault response block, with retry timer model
// assumes SAMPLE_CYCLES is shrunk to 4 so deglitch counts stay short
`timescale 1ns/1ps
module ocfr_core_tb_top;
    import ocfr_pkg::*;
    // design inputs
    logic sys_clk = 1'b0, rst = 1'b1, resp_wr = 1'b0, resp_is_uc = 1'b0;
    logic [1:0] resp_page = 2'h0;
    logic [7:0] resp_wdata = 8'h00;
    logic [2:0] retry_count = 3'h0;
    logic [3:0] oc_fault_raw = 4'h0, uc_fault_raw = 4'h0, track_en = 4'h0;
    logic [3:0] chan_on_cmd = 4'hF, other_fault_off = 4'h0, retry_tick;
    logic bias_sense_input = 1'b1, clear_faults = 1'b0;
    // design outputs
    logic [7:0] oc_rb [4], uc_rb [4], status_iout_q [4];
    logic [7:0] status_byte_q;
    logic [15:0] status_word_q;
    logic host_alert_n;
    ocfr_chan_cmd_t chan_cmd_q [4];
    logic [3:0] faulted_off_q;
    // sticky record of one-cycle command pulses, never cleared
    logic [3:0] seen_shut = 4'h0, seen_seq = 4'h0;
    int restarts [4] = '{0, 0, 0, 0};
    int err_count = 0, total_checks = 0, cycles = 0;

    always #5 sys_clk = ~sys_clk;

    ocfr_core #(.SAMPLE_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst(rst),
        .resp_wr(resp_wr), .resp_is_uc(resp_is_uc), .resp_page(resp_page),
        .resp_wdata(resp_wdata), .retry_count(retry_count),
        .oc_fault_raw(oc_fault_raw), .uc_fault_raw(uc_fault_raw),
        .track_en(track_en), .chan_on_cmd(chan_on_cmd),
        .other_fault_off(other_fault_off), .retry_tick(retry_tick),
        .bias_sense_input(bias_sense_input), .clear_faults(clear_faults),
        .overcurrent_fault_response(oc_rb),
        .undercurrent_fault_response(uc_rb),
        .status_iout_q(status_iout_q), .status_byte_q(status_byte_q),
        .status_word_q(status_word_q), .host_alert_n(host_alert_n),
        .chan_cmd_q(chan_cmd_q), .faulted_off_q(faulted_off_q));

    ocfr_chan_model #(.RETRY_WAIT(6)) partner (.sys_clk(sys_clk),
        .rst(rst), .faulted_off(faulted_off_q), .retry_tick(retry_tick));

    // pulses last one cycle, so catch them at every edge
    always @(posedge sys_clk) begin
        cycles++;
        for (int i = 0; i < 4; i++) begin
            if (chan_cmd_q[i].shutdown_now === 1'b1) seen_shut[i] <= 1'b1;
            if (chan_cmd_q[i].sequence_off === 1'b1) seen_seq[i] <= 1'b1;
            if (chan_cmd_q[i].restart_req === 1'b1) restarts[i]++;
        end
        // hang guard: the whole sequence needs well under 1000 cycles
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // register write, then readback once the two-cycle latency has passed
    task automatic wr(bit uc, int ch, logic [7:0] data);
        resp_is_uc = uc;
        resp_page = ch[1:0];
        resp_wdata = data;
        resp_wr = 1'b1;
        cyc(1);
        resp_wr = 1'b0;
        cyc(2);
        chk("readback", {8'h00, data}, {8'h00, uc ? uc_rb[ch] : oc_rb[ch]});
    endtask

    // hold a supervisor fault flag for n cycles
    task automatic fault(bit uc, int ch, int n);
        if (uc) uc_fault_raw[ch] = 1'b1;
        else oc_fault_raw[ch] = 1'b1;
        cyc(n);
        uc_fault_raw[ch] = 1'b0;
        oc_fault_raw[ch] = 1'b0;
    endtask

    task automatic clr();
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        cyc(2);
    endtask

    initial begin
        cyc(3);
        rst = 1'b0;
        chk("alert after reset", 16'h0001, {15'h0, host_alert_n});
        chk("status byte after reset", 16'h0000, {8'h00, status_byte_q});
        chk("oc byte after reset", 16'h0000, {8'h00, oc_rb[0]});
        // one action code per channel: 11b, 01b, 10b, 00b
        retry_count = 3'h2;
        track_en = 4'h4;
        wr(0, 0, 8'hC0);
        wr(1, 1, 8'h40);
        wr(0, 2, 8'h8A);
        wr(0, 3, 8'h00);
        // immediate shutdown, no deglitch, no restart
        fault(0, 0, 2);
        cyc(3);
        chk("iout ch0", 16'h0080, {8'h00, status_iout_q[0]});
        chk("byte bit", 16'h0001, {15'h0, status_byte_q[4]});
        chk("word bit", 16'h0001, {15'h0, status_word_q[14]});
        chk("alert", 16'h0000, {15'h0, host_alert_n});
        chk("shut ch0", 16'h0001, {15'h0, seen_shut[0]});
        cyc(25);
        chk("restarts ch0", 16'h0000, restarts[0][15:0]);
        clr();
        chk("alert cleared", 16'h0001, {15'h0, host_alert_n});
        chk("status cleared", 16'h0000, {8'h00, status_byte_q});
        chk("still off", 16'h0001, {15'h0, faulted_off_q[0]});
        chan_on_cmd[0] = 1'b0;
        cyc(2);
        chan_on_cmd[0] = 1'b1;
        cyc(2);
        chk("latch cleared", 16'h0000, {15'h0, faulted_off_q[0]});
        // report-only actions keep the channels running
        fault(1, 1, 3);
        fault(0, 3, 3);
        cyc(3);
        chk("iout ch1", 16'h0010, {8'h00, status_iout_q[1]});
        chk("iout ch3", 16'h0080, {8'h00, status_iout_q[3]});
        chk("alert uc", 16'h0000, {15'h0, host_alert_n});
        chk("no off 1 3", 16'h0000, {12'h0, faulted_off_q & 4'hA});
        chk("no cmd 1 3", 16'h0000, {12'h0, (seen_shut | seen_seq) & 4'hA});
        clr();
        // delayed action: a short glitch is ignored, a long fault trips
        fault(0, 2, 3);
        cyc(10);
        chk("glitch alert", 16'h0001, {15'h0, host_alert_n});
        oc_fault_raw[2] = 1'b1;
        cyc(4);
        chk("still running", 16'h0000, {15'h0, faulted_off_q[2]});
        cyc(10);
        chk("seq off ch2", 16'h0001, {15'h0, seen_seq[2]});
        chk("no hard off ch2", 16'h0000, {15'h0, seen_shut[2]});
        cyc(100);
        chk("restarts ch2", 16'h0002, restarts[2][15:0]);
        chk("gave up ch2", 16'h0001, {15'h0, faulted_off_q[2]});
        oc_fault_raw[2] = 1'b0;
        // another fault shutting the unit down stops retries
        wr(0, 3, 8'hC8);
        other_fault_off[3] = 1'b1;
        fault(0, 3, 2);
        cyc(30);
        chk("restarts ch3", 16'h0000, restarts[3][15:0]);
        summarize();
    end
endmodule

// ==== rtl/ocfr_core.sv ====
// over-current and under-current fault response for four channels
// assumes fault flags come from the fast supervisor in sys_clk domain,
// sequencer and retry timer outside; registers written by command decoder
`timescale 1ns/1ps

// Operation
// - fault sets status word, iout bits; status byte bit on over-current only
// - any current fault pulls alert low
// - action 00b or 01b keeps channel running
// - no current clamping, report only
// - action 10b acts after delay if persisting
// - shutdown is immediate or sequenced per track
// - after shutdown follow restart field
// - restart 000b never restarts, stays off
// - nonzero restart retries up to global count
// - off command, bias loss, other fault stop
// - restart setting taken at off-then-on; code uses the field read at the trip
// - low field is deglitch sample count
// - zero delay field adds no deglitch
// - nonzero field deglitches that many samples
// - clear faults resets status, not latch
// - latch cleared by control, operation, bias
module ocfr_core
    import ocfr_pkg::*;
#(
    parameter int CH = NUM_CH,
    parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register writes from the command decoder
    input wire logic resp_wr,
    input wire logic resp_is_uc,
    input wire logic [1:0] resp_page,
    input wire logic [7:0] resp_wdata,
    input wire logic [2:0] retry_count,
    // supervisor fault flags
    input wire logic [CH-1:0] oc_fault_raw,
    input wire logic [CH-1:0] uc_fault_raw,
    // channel state and clearing events
    input wire logic [CH-1:0] track_en,
    input wire logic [CH-1:0] chan_on_cmd,
    input wire logic [CH-1:0] other_fault_off,
    input wire logic [CH-1:0] retry_tick,
    input wire logic bias_sense_input,
    input wire logic clear_faults,
    // register read back
    output logic [7:0] overcurrent_fault_response [CH],
    output logic [7:0] undercurrent_fault_response [CH],
    // status images
    output logic [7:0] status_iout_q [CH],
    output logic [7:0] status_byte_q,
    output logic [15:0] status_word_q,
    // host alert, active low
    output logic host_alert_n,
    // channel controls
    output ocfr_chan_cmd_t chan_cmd_q [CH],
    output logic [CH-1:0] faulted_off_q
);
    // sample tick counter shared by all deglitch counters
    logic [15:0] tick_cnt_q;
    logic sample_tick;
    assign sample_tick = (tick_cnt_q == 16'(SAMPLE_CYCLES - 1));

    // free running sample tick generator
    always_ff @(posedge sys_clk) begin
        if (rst || sample_tick) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // response byte storage, one pair per channel
    ocfr_resp_t oc_q [CH];
    ocfr_resp_t uc_q [CH];

    // register writes land only in the addressed channel's byte
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < CH; i++) begin
            if (rst) begin
                oc_q[i] <= OC_RESP_RST;
                uc_q[i] <= UC_RESP_RST;
            end else if (resp_wr && resp_page == 2'(i)) begin
                if (resp_is_uc) begin
                    uc_q[i] <= resp_wdata;
                end else begin
                    oc_q[i] <= resp_wdata;
                end
            end
        end
    end

    // read back is registered so outputs stay flop driven
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < CH; i++) begin
            overcurrent_fault_response[i] <= oc_q[i];
            undercurrent_fault_response[i] <= uc_q[i];
        end
    end

    // per-channel per-type deglitch counters and qualified faults
    logic [2:0] oc_dg_q [CH];
    logic [2:0] uc_dg_q [CH];
    logic [CH-1:0] oc_qual;
    logic [CH-1:0] uc_qual;
    logic [CH-1:0] oc_trip;
    logic [CH-1:0] uc_trip;
    logic [CH-1:0] any_trip;

    // a fault is qualified once it has lasted the delay field in samples
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            oc_qual[i] = oc_fault_raw[i] &&
                (oc_q[i].deglitch == 3'h0 ||
                 oc_dg_q[i] >= oc_q[i].deglitch);
            uc_qual[i] = uc_fault_raw[i] &&
                (uc_q[i].deglitch == 3'h0 ||
                 uc_dg_q[i] >= uc_q[i].deglitch);
            // 10b waits the delay, 11b acts on the raw fault at once
            oc_trip[i] = (oc_q[i].action == ACT_DELAYED && oc_qual[i]) ||
                (oc_q[i].action == ACT_IMMEDIATE && oc_fault_raw[i]);
            uc_trip[i] = (uc_q[i].action == ACT_DELAYED && uc_qual[i]) ||
                (uc_q[i].action == ACT_IMMEDIATE && uc_fault_raw[i]);
            any_trip[i] = oc_trip[i] || uc_trip[i];
        end
    end

    // count samples while the fault persists; a gap restarts it
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < CH; i++) begin
            if (rst || !oc_fault_raw[i]) begin
                oc_dg_q[i] <= 3'h0;
            end else if (sample_tick && oc_dg_q[i] != 3'h7) begin
                oc_dg_q[i] <= oc_dg_q[i] + 3'h1;
            end
            if (rst || !uc_fault_raw[i]) begin
                uc_dg_q[i] <= 3'h0;
            end else if (sample_tick && uc_dg_q[i] != 3'h7) begin
                uc_dg_q[i] <= uc_dg_q[i] + 3'h1;
            end
        end
    end

    // status: faults are flagged once qualified by the delay field, whatever the action;
    // the set wins over a same-cycle clear
    logic [CH-1:0] oc_flag;
    logic [CH-1:0] uc_flag;
    always_comb begin
        for (int i = 0; i < CH; i++) begin
            oc_flag[i] = oc_fault_raw[i] &&
                (oc_q[i].deglitch == 3'h0 || oc_dg_q[i] >= oc_q[i].deglitch);
            uc_flag[i] = uc_fault_raw[i] &&
                (uc_q[i].deglitch == 3'h0 || uc_dg_q[i] >= uc_q[i].deglitch);
        end
    end

    // status register updates
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_byte_q <= 8'h00;
            status_word_q <= 16'h0000;
            host_alert_n <= 1'b1;
            for (int i = 0; i < CH; i++) begin
                status_iout_q[i] <= 8'h00;
            end
        end else begin
            if (clear_faults) begin
                status_byte_q <= 8'h00;
                status_word_q <= 16'h0000;
                host_alert_n <= 1'b1;
                for (int i = 0; i < CH; i++) begin
                    status_iout_q[i] <= 8'h00;
                end
            end
            for (int i = 0; i < CH; i++) begin
                if (oc_flag[i]) begin
                    status_iout_q[i][IOUT_OC_BIT] <= 1'b1;
                    status_byte_q[SB_IOUT_OC_BIT] <= 1'b1;
                end
                if (uc_flag[i]) begin
                    status_iout_q[i][IOUT_UC_BIT] <= 1'b1;
                end
            end
            if (|(oc_flag | uc_flag)) begin
                status_word_q[SW_IOUT_BIT] <= 1'b1;
                host_alert_n <= 1'b0;
            end
        end
    end

    // channel fault state machine
    typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_WAIT} ocfr_state_t;
    ocfr_state_t st_q [CH];
    logic [2:0] restart_q [CH];
    logic [2:0] tries_q [CH];
    logic [CH-1:0] on_prev_q;
    logic bias_prev_q;

    // the output current is never clamped here: actions only
    // turn channels off or back on, limits stay a report level
    always_ff @(posedge sys_clk) begin
        // edge history follows the pins during reset too, so a pin
        // already high at release is not taken as a fresh rising edge
        bias_prev_q <= bias_sense_input;
        for (int i = 0; i < CH; i++) begin
            on_prev_q[i] <= chan_on_cmd[i];
            chan_cmd_q[i] <= '0;
            if (rst) begin
                st_q[i] <= ST_RUN;
                restart_q[i] <= 3'h0;
                tries_q[i] <= 3'h0;
                faulted_off_q[i] <= 1'b0;
            end else if ((chan_on_cmd[i] && !on_prev_q[i]) ||
                         (bias_sense_input && !bias_prev_q)) begin
                // off-then-on or bias cycle clears the latch and
                // picks up the restart field that now stands
                st_q[i] <= ST_RUN;
                faulted_off_q[i] <= 1'b0;
                tries_q[i] <= 3'h0;
                restart_q[i] <= any_trip[i] && uc_trip[i] && !oc_trip[i]
                    ? uc_q[i].restart : oc_q[i].restart;
            end else begin
                case (st_q[i])
                    ST_RUN: begin
                        // actions 00b and 01b fall through here
                        if (any_trip[i]) begin
                            chan_cmd_q[i].shutdown_now <= !track_en[i];
                            chan_cmd_q[i].sequence_off <= track_en[i];
                            faulted_off_q[i] <= 1'b1;
                            restart_q[i] <= oc_trip[i] ? oc_q[i].restart
                                                       : uc_q[i].restart;
                            st_q[i] <= ST_OFF;
                        end
                    end
                    ST_OFF: begin
                        if (restart_q[i] == 3'h0 ||
                            tries_q[i] >= retry_count) begin
                            st_q[i] <= ST_OFF;
                        end else begin
                            st_q[i] <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (!chan_on_cmd[i] || !bias_sense_input ||
                            other_fault_off[i]) begin
                            st_q[i] <= ST_OFF;
                            tries_q[i] <= retry_count;
                        end else if (retry_tick[i]) begin
                            chan_cmd_q[i].restart_req <= 1'b1;
                            tries_q[i] <= tries_q[i] + 3'h1;
                            faulted_off_q[i] <= 1'b0;
                            st_q[i] <= ST_RUN;
                        end
                    end
                    default: st_q[i] <= ST_RUN;
                endcase
            end
        end
    end

    // alert drops in the cycle after a qualified fault
    AST_ALERT: assert property (@(posedge sys_clk) disable iff (rst)
        (|(oc_flag | uc_flag)) |=> !host_alert_n)
        else $error("alert not asserted after fault");

    // channel 0 latched off with a zero restart field and its on command low issues no restart in the next cycle
    AST_NORETRY: assert property (@(posedge sys_clk) disable iff (rst)
        (st_q[0] == ST_OFF && restart_q[0] == 3'h0 && !chan_on_cmd[0])
        |=> !chan_cmd_q[0].restart_req)
        else $error("restart issued with zero setting");

    // ignore actions never shut a channel down
    AST_CONTINUE: assert property (@(posedge sys_clk) disable iff (rst)
        (oc_q[0].action[1] == 1'b0 && uc_q[0].action[1] == 1'b0)
        |=> !chan_cmd_q[0].shutdown_now && !chan_cmd_q[0].sequence_off)
        else $error("shutdown under continue action");

    // channel 0 trips while running and no latch clear competes
    sequence s_trip0;
        st_q[0] == ST_RUN && any_trip[0] &&
        !(chan_on_cmd[0] && !on_prev_q[0]) &&
        !(bias_sense_input && !bias_prev_q);
    endsequence

    // channel 0 sits latched off with no clearing edge
    sequence s_latched0;
        st_q[0] == ST_OFF && faulted_off_q[0] &&
        !(chan_on_cmd[0] && !on_prev_q[0]) &&
        !(bias_sense_input && !bias_prev_q);
    endsequence

    // a trip gives exactly one kind of off command and latches off
    AST_SHUT: assert property (@(posedge sys_clk) disable iff (rst)
        s_trip0 |=> faulted_off_q[0] &&
        (chan_cmd_q[0].shutdown_now != chan_cmd_q[0].sequence_off))
        else $error("trip without single off command");

    // tracking channels are sequenced off rather than cut
    AST_TRACK: assert property (@(posedge sys_clk) disable iff (rst)
        s_trip0 ##0 track_en[0] |=> chan_cmd_q[0].sequence_off)
        else $error("tracking channel not sequenced off");

    // clearing faults never releases a latched-off channel
    AST_LATCH: assert property (@(posedge sys_clk) disable iff (rst)
        s_latched0 |=> faulted_off_q[0])
        else $error("latched off state lost");

    // a clear with no new fault releases the alert and status byte
    AST_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
        (clear_faults && !(|(oc_flag | uc_flag)))
        |=> host_alert_n && status_byte_q == 8'h00)
        else $error("clear faults did not release status");
endmodule

// ==== rtl/ocfr_pkg.sv ====
// package for the output current fault response block
// assumes one 100 MHz clock and registers loaded from the command decoder
package ocfr_pkg;
    // channel count and response byte field positions
    localparam int NUM_CH = 4;
    localparam int ACT_MSB = 7;
    localparam int ACT_LSB = 6;
    localparam int RST_MSB = 5;
    localparam int RST_LSB = 3;
    localparam int DLY_MSB = 2;
    localparam int DLY_LSB = 0;
    // reset values of the response bytes and retry count
    localparam logic [7:0] OC_RESP_RST = 8'h00;
    localparam logic [7:0] UC_RESP_RST = 8'h00;
    localparam logic [2:0] RETRY_CNT_RST = 3'h0;
    // action encodings
    localparam logic [1:0] ACT_IGNORE0 = 2'h0;
    localparam logic [1:0] ACT_IGNORE1 = 2'h1;
    localparam logic [1:0] ACT_DELAYED = 2'h2;
    localparam logic [1:0] ACT_IMMEDIATE = 2'h3;
    // supervisor sample period, in ns, and clock period in ns
    localparam int SAMPLE_NS = 12200;
    localparam int CLK_NS = 10;
    // longest-time style count: round down, at least one cycle
    localparam int SAMPLE_CYC = (SAMPLE_NS / CLK_NS) < 1 ? 1 :
                                (SAMPLE_NS / CLK_NS);
    // status bit positions in the per-channel status_iout image
    localparam int IOUT_OC_BIT = 7;
    localparam int IOUT_UC_BIT = 4;
    // status_byte / status_word summary bit positions
    localparam int SB_IOUT_OC_BIT = 4;
    localparam int SW_IOUT_BIT = 14;

    // per-channel fault response byte split into fields
    typedef struct packed {
        logic [1:0] action;
        logic [2:0] restart;
        logic [2:0] deglitch;
    } ocfr_resp_t;

    // channel-side controls toward the sequencer
    typedef struct packed {
        logic shutdown_now;
        logic sequence_off;
        logic restart_req;
    } ocfr_chan_cmd_t;
endpackage
